// >>> rtl/audio_dma_map.vh
`ifndef AUDIO_DMA_MAP_VH
`define AUDIO_DMA_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_PIN_STATUS 9'h000
`define OFS_PIN_CONTROL 9'h004
`define OFS_STATUS_WORD 9'h008
`define OFS_COMMAND_WORD 9'h00c
`define OFS_IRQ_MIRROR 9'h010
`define OFS_IRQ_CLEAR 9'h012
`define OFS_TRAP_STATUS 9'h014
`define OFS_TRAP_ENABLE 9'h018
`define OFS_FAST_READ_DATA 9'h020
`define OFS_BM_REGION 3'h1
`define OFS_TOP_MIRROR 9'h100
`define OFS_TOP_CLEAR 9'h102

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMD_ENGAGE 0
`define CMD_DIR 3
`define DESC_EOT 31
`define DESC_EOP 30
`define DESC_JMP 29
`define TEN_SB 0
`define TEN_FM 1
`define TEN_SB_SEL_LO 2
`define TEN_FAST_READ 4
`define TEN_FAST_WRITE 11
`define TS_WRITE 10
`define TS_TRAP 11
`define TS_FW_PEND 14
`define TS_A1 15
`define IRQ_PIN 12
`define IRQ_TRAP 13

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define RST_WORD 32'h0000_0000
`define RST_HALF 16'h0000
`define DESC_STEP 32'h0000_0008
`define DESC_WORD1 32'h0000_0004
`define JMP_MASK 32'hffff_ffe0
`define SIZE_ZERO_LEN 17'h1_0000
`define STEP_WIDE 17'h0_0004
`define STEP_NARROW 17'h0_0002
`define FRAME_LAST 8'hff
`define SYNC_BITS 8'h10
`define RX_LAST 8'h37
`define FM_PORT_HI 8'he2
`define SB_PORT_BASE 6'h22

`endif

// >>> rtl/audio_dma_core.v
// Notes on behaviour
// - Reading the audio status clears error and page-end flags, bits 1 and 0.
// - Writing one to command bit 0 engages the master and starts fetching.
// - Master reads descriptor at table pointer, then advances pointer by 08h.
// - Data moves on link transfer requests; descriptor flags decide what next.
// - Page-end completion raises management interrupt and continues onward.
// - Jump descriptor supplies next descriptor address instead of the pointer.
// - Second page-end while first uncleared sets error and pauses master.
// - Disable only honoured when paused on error or finished at table end.
// - Speaker tone drives its output when that pin function is chosen.
// - Codec status register loads every valid status word slot.
// - Codec command register is sent in the frame's control word slot.
// - Codec pin control enables a codec pin event as interrupt source.
// - Top status at 00h and 02h identical; only 02h read clears (here at 100h and 102h).
// - Audio status at 10h without side effect, at 12h read-to-clear.
// - Read-only 14h shows trap interrupt and fast-write capture bits.
// - Trap enable bit 4 answers emulated status reads without interrupt.
// - Fast reads: 388h-38Bh, 2x0h-2x3h, 2x8h, 2x9h, mapping must be enabled.
// - Trap enable bit 11 turns on fast-write capture of index-data pairs.
// - First access stores data and address bit 1 at 14h[15]; second traps.
// - Fast-write ports: 388h, 38Ah, 38Bh, 2x0h, 2x2h, 2x8h.
// - Descriptor: pointer word, then 16-bit size with table/page/jump flags.
// - Status read while paused clears both flags and resumes the master.
//
// Strobed register access was left to the implementer.
`include "audio_dma_map.vh"
`timescale 1ns/1ps
`default_nettype none

module audio_dma_core #(
	parameter NUM_BM = 6
) (
	input wire I_SYS_CLK,
	input wire I_NRST,
	input wire [8:0] I_ADDR,
	input wire [31:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	output wire [31:0] O_RDATA,
	output wire O_MEM_REQ,
	output wire O_MEM_WE,
	output wire [31:0] O_MEM_ADDR,
	output wire [31:0] O_MEM_WDATA,
	input wire I_MEM_ACK,
	input wire [31:0] I_MEM_RDATA,
	input wire [5:0] I_XFER_REQ,
	output wire [31:0] O_PLAY_DATA,
	output wire [5:0] O_PLAY_VALID,
	input wire [31:0] I_CAP_DATA,
	input wire I_LINK_CLK,
	input wire I_FIRST_CODEC_SERIAL_IN,
	output wire O_LINK_SYNC,
	output wire O_LINK_SERIAL_OUT,
	input wire [15:0] I_CODEC_PIN_IN,
	input wire I_SPEAKER_TONE,
	input wire I_PIN_FUNCTION_SELECT,
	output wire O_SPEAKER_TONE_OUT,
	input wire I_IO_VALID,
	input wire I_IO_WRITE,
	input wire [9:0] I_IO_ADDR,
	input wire [7:0] I_IO_WDATA,
	output wire O_IO_CLAIM,
	output wire [7:0] O_IO_RDATA,
	output wire O_SYSTEM_MGMT_INTERRUPT
);

// ----------------------------------------
// Reset release and pin synchronisers
// ----------------------------------------
localparam ST_IDLE = 5'h01;
localparam ST_FETCH = 5'h02;
localparam ST_XFER = 5'h04;
localparam ST_PAUSE = 5'h08;
localparam ST_DONE = 5'h10;

reg rst_meta_reg, rst_n;
always @(posedge I_SYS_CLK or negedge I_NRST) begin
	if (!I_NRST) begin
		rst_meta_reg <= 1'b0;
		rst_n <= 1'b0;
	end else begin
		rst_meta_reg <= 1'b1;
		rst_n <= rst_meta_reg;
	end
end

reg [1:0] clk_meta_reg, din_meta_reg;
reg clk_sync_reg, din_sync_reg, clk_prev_reg;
always @(posedge I_SYS_CLK or negedge rst_n) begin
	if (!rst_n) begin
		clk_meta_reg <= 2'h0;
		din_meta_reg <= 2'h0;
		clk_sync_reg <= 1'b0;
		din_sync_reg <= 1'b0;
		clk_prev_reg <= 1'b0;
	end else begin
		clk_meta_reg <= {clk_meta_reg[0], I_LINK_CLK};
		din_meta_reg <= {din_meta_reg[0], I_FIRST_CODEC_SERIAL_IN};
		clk_sync_reg <= clk_meta_reg[1];
		din_sync_reg <= din_meta_reg[1];
		clk_prev_reg <= clk_sync_reg;
	end
end
// Codec-made clock, edges found by sampling
wire link_rise = clk_sync_reg & ~clk_prev_reg;
wire link_fall = ~clk_sync_reg & clk_prev_reg;

// ----------------------------------------
// Helpers
// ----------------------------------------
function [16:0] bm_step;
	input [2:0] idx;
	begin
		bm_step = (idx < 3'h2) ? `STEP_WIDE : `STEP_NARROW;
	end
endfunction

function fast_read_port;
	input [9:0] a;
	input fm_on, sb_on;
	input [1:0] sel;
	begin
		fast_read_port = (fm_on && a[9:2] == `FM_PORT_HI) ||
			(sb_on && a[9:4] == (`SB_PORT_BASE + {3'h0, sel, 1'b0}) &&
			(a[3:2] == 2'h0 || a[3:1] == 3'h4));
	end
endfunction

function fast_write_port;
	input [9:0] a;
	input fm_on, sb_on;
	input [1:0] sel;
	begin
		fast_write_port = (fm_on && (a == 10'h388 || a == 10'h38a ||
			a == 10'h38b)) ||
			(sb_on && a[9:4] == (`SB_PORT_BASE + {3'h0, sel, 1'b0}) &&
			(a[3:0] == 4'h0 || a[3:0] == 4'h2 ||
			a[3:0] == 4'h8));
	end
endfunction

// ----------------------------------------
// Register state
// ----------------------------------------
reg [31:0] pin_ctrl_reg, status_word_reg, command_reg, rdata_reg;
reg [15:0] trap_en_reg, pin_prev_reg;
reg [7:0] fast_data_reg;
reg [31:0] trap_stat_reg;
reg pin_flag_reg, top_reg, cmd_pend_reg;
reg [15:0] irq_prev_reg;
reg [NUM_BM-1:0] eop_st_reg, err_st_reg;

wire [2:0] bm_idx = I_ADDR[5:3];
wire bm_hit = (I_ADDR[8:6] == `OFS_BM_REGION) && (bm_idx < NUM_BM);
wire st_clr = I_RD && (I_ADDR == `OFS_IRQ_CLEAR);
wire top_clr = I_RD && (I_ADDR == `OFS_TOP_CLEAR);

reg [15:0] irq_vec;
integer k;
always @* begin
	irq_vec = `RST_HALF;
	for (k = 0; k < NUM_BM; k = k + 1) begin
		irq_vec[2 * k] = eop_st_reg[k];
		irq_vec[2 * k + 1] = err_st_reg[k];
	end
	irq_vec[`IRQ_PIN] = pin_flag_reg;
	irq_vec[`IRQ_TRAP] = trap_stat_reg[`TS_TRAP];
end

// ----------------------------------------
// Bus masters and memory port
// ----------------------------------------
reg [4:0] state_reg [0:NUM_BM-1];
reg [31:0] ptr_reg [0:NUM_BM-1];
reg [31:0] buf_reg [0:NUM_BM-1];
reg [16:0] cnt_reg [0:NUM_BM-1];
reg [NUM_BM-1:0] phase_reg, dir_reg, pend_reg, eot_f_reg, eop_f_reg;
reg mem_req_reg, mem_we_reg, mem_fetch_reg;
reg [31:0] mem_addr_reg, mem_wdata_reg, play_data_reg;
reg [2:0] owner_reg;
reg [5:0] play_valid_reg;

reg gnt;
reg [2:0] gnt_idx;
integer g;
always @* begin
	gnt = 1'b0;
	gnt_idx = 3'h0;
	for (g = NUM_BM - 1; g >= 0; g = g - 1) begin
		// Link requests pace data moves
		if (state_reg[g] == ST_FETCH ||
			(state_reg[g] == ST_XFER && pend_reg[g])) begin
			gnt = ~mem_req_reg;
			gnt_idx = g[2:0];
		end
	end
end
wire mem_done = mem_req_reg & I_MEM_ACK;

integer i;
always @(posedge I_SYS_CLK or negedge rst_n) begin
	if (!rst_n) begin
		for (i = 0; i < NUM_BM; i = i + 1) begin
			state_reg[i] <= ST_IDLE;
			ptr_reg[i] <= `RST_WORD;
			buf_reg[i] <= `RST_WORD;
			cnt_reg[i] <= 17'h0;
		end
		phase_reg <= {NUM_BM{1'b0}};
		dir_reg <= {NUM_BM{1'b0}};
		pend_reg <= {NUM_BM{1'b0}};
		eot_f_reg <= {NUM_BM{1'b0}};
		eop_f_reg <= {NUM_BM{1'b0}};
		eop_st_reg <= {NUM_BM{1'b0}};
		err_st_reg <= {NUM_BM{1'b0}};
		mem_req_reg <= 1'b0;
		mem_we_reg <= 1'b0;
		mem_fetch_reg <= 1'b0;
		mem_addr_reg <= `RST_WORD;
		mem_wdata_reg <= `RST_WORD;
		owner_reg <= 3'h0;
		play_data_reg <= `RST_WORD;
		play_valid_reg <= 6'h00;
	end else begin
		play_valid_reg <= 6'h00;
		if (mem_done)
			mem_req_reg <= 1'b0;
		if (gnt) begin
			mem_req_reg <= 1'b1;
			owner_reg <= gnt_idx;
			mem_fetch_reg <= (state_reg[gnt_idx] == ST_FETCH);
			if (state_reg[gnt_idx] == ST_FETCH) begin
				mem_we_reg <= 1'b0;
				mem_addr_reg <= phase_reg[gnt_idx] ?
					ptr_reg[gnt_idx] + `DESC_WORD1 : ptr_reg[gnt_idx];
			end else begin
				mem_we_reg <= gnt_idx[0];
				mem_addr_reg <= buf_reg[gnt_idx];
				mem_wdata_reg <= I_CAP_DATA;
			end
		end
		for (i = 0; i < NUM_BM; i = i + 1) begin
			pend_reg[i] <= (pend_reg[i] & ~(gnt && gnt_idx == i &&
				state_reg[i] == ST_XFER)) | I_XFER_REQ[i];
			if (I_WR && bm_hit && bm_idx == i && !I_ADDR[2]) begin
				dir_reg[i] <= I_WDATA[`CMD_DIR];
				if (I_WDATA[`CMD_ENGAGE] && state_reg[i] == ST_IDLE) begin
					state_reg[i] <= ST_FETCH;
					phase_reg[i] <= 1'b0;
				end else if (!I_WDATA[`CMD_ENGAGE] &&
					(state_reg[i] == ST_PAUSE || state_reg[i] == ST_DONE))
					state_reg[i] <= ST_IDLE;
			end
			if (I_WR && bm_hit && bm_idx == i && I_ADDR[2] &&
				state_reg[i] == ST_IDLE)
				ptr_reg[i] <= I_WDATA & `JMP_MASK;
			if (st_clr) begin
				eop_st_reg[i] <= 1'b0;
				err_st_reg[i] <= 1'b0;
				if (state_reg[i] == ST_PAUSE)
					state_reg[i] <= eot_f_reg[i] ? ST_DONE : ST_FETCH;
			end
			if (mem_done && owner_reg == i && mem_fetch_reg) begin
				if (!phase_reg[i]) begin
					buf_reg[i] <= I_MEM_RDATA;
					phase_reg[i] <= 1'b1;
				end else begin
					phase_reg[i] <= 1'b0;
					eot_f_reg[i] <= I_MEM_RDATA[`DESC_EOT];
					eop_f_reg[i] <= I_MEM_RDATA[`DESC_EOP];
					cnt_reg[i] <= (I_MEM_RDATA[15:0] == 16'h0) ?
						`SIZE_ZERO_LEN : {1'b0, I_MEM_RDATA[15:0]};
					if (I_MEM_RDATA[`DESC_JMP])
						ptr_reg[i] <= buf_reg[i] & `JMP_MASK;
					else begin
						ptr_reg[i] <= ptr_reg[i] + `DESC_STEP;
						state_reg[i] <= ST_XFER;
					end
				end
			end
			if (mem_done && owner_reg == i && !mem_fetch_reg) begin
				if (!mem_we_reg) begin
					play_data_reg <= I_MEM_RDATA;
					play_valid_reg[i] <= 1'b1;
				end
				buf_reg[i] <= buf_reg[i] + {15'h0, bm_step(owner_reg)};
				if (cnt_reg[i] > bm_step(owner_reg))
					cnt_reg[i] <= cnt_reg[i] - bm_step(owner_reg);
				else begin
					cnt_reg[i] <= 17'h0;
					if (eop_f_reg[i] && eop_st_reg[i] && !st_clr) begin
						err_st_reg[i] <= 1'b1;
						state_reg[i] <= ST_PAUSE;
					end else begin
						if (eop_f_reg[i])
							eop_st_reg[i] <= 1'b1;
						// Table end parks the master
						state_reg[i] <= eot_f_reg[i] ? ST_DONE : ST_FETCH;
					end
				end
			end
		end
	end
end

// ----------------------------------------
// Codec link framing
// ----------------------------------------
reg [7:0] bit_cnt_reg;
reg [55:0] tx_shift_reg, rx_shift_reg;
reg sync_reg, sdout_reg;
wire [55:0] tx_frame = {cmd_pend_reg, cmd_pend_reg, cmd_pend_reg, 13'h0,
	command_reg[31:24], 12'h0, command_reg[15:0], 4'h0};
wire [55:0] rx_frame = {rx_shift_reg[54:0], din_sync_reg};
wire frame_load = link_rise && bit_cnt_reg == `FRAME_LAST;

always @(posedge I_SYS_CLK or negedge rst_n) begin
	if (!rst_n) begin
		bit_cnt_reg <= `FRAME_LAST;
		tx_shift_reg <= 56'h0;
		rx_shift_reg <= 56'h0;
		sync_reg <= 1'b0;
		sdout_reg <= 1'b0;
		status_word_reg <= `RST_WORD;
	end else begin
		if (link_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 8'h01;
			sync_reg <= (bit_cnt_reg + 8'h01) < `SYNC_BITS;
			if (frame_load) begin
				sdout_reg <= tx_frame[55];
				tx_shift_reg <= {tx_frame[54:0], 1'b0};
			end else begin
				sdout_reg <= tx_shift_reg[55];
				tx_shift_reg <= {tx_shift_reg[54:0], 1'b0};
			end
		end
		if (link_fall) begin
			rx_shift_reg <= rx_frame;
			if (bit_cnt_reg == `RX_LAST && rx_frame[55] && rx_frame[53])
				status_word_reg <= {1'b0, rx_frame[38:32], 8'h00,
					rx_frame[19:4]};
		end
	end
end

// ----------------------------------------
// Registers, traps and interrupt
// ----------------------------------------
reg claim_reg, tone_reg;
reg [7:0] io_rdata_reg;
wire sb_on = trap_en_reg[`TEN_SB];
wire fm_on = trap_en_reg[`TEN_FM];
wire [1:0] sb_sel = trap_en_reg[`TEN_SB_SEL_LO+1:`TEN_SB_SEL_LO];
wire sb_any = sb_on &&
	I_IO_ADDR[9:4] == (`SB_PORT_BASE + {3'h0, sb_sel, 1'b0});
wire io_hit = sb_any || (fm_on && I_IO_ADDR[9:2] == `FM_PORT_HI);
wire pin_event = |(I_CODEC_PIN_IN & ~pin_prev_reg & pin_ctrl_reg[15:0]);

always @(posedge I_SYS_CLK or negedge rst_n) begin
	if (!rst_n) begin
		pin_ctrl_reg <= `RST_WORD;
		command_reg <= `RST_WORD;
		trap_en_reg <= `RST_HALF;
		fast_data_reg <= 8'h00;
		trap_stat_reg <= `RST_WORD;
		pin_prev_reg <= `RST_HALF;
		pin_flag_reg <= 1'b0;
		cmd_pend_reg <= 1'b0;
		top_reg <= 1'b0;
		irq_prev_reg <= `RST_HALF;
		rdata_reg <= `RST_WORD;
		claim_reg <= 1'b0;
		io_rdata_reg <= 8'h00;
		tone_reg <= 1'b0;
	end else begin
		tone_reg <= I_PIN_FUNCTION_SELECT & I_SPEAKER_TONE;
		pin_prev_reg <= I_CODEC_PIN_IN;
		if (frame_load)
			cmd_pend_reg <= 1'b0;
		if (I_WR) begin
			case (I_ADDR)
			`OFS_PIN_CONTROL: pin_ctrl_reg <= I_WDATA;
			`OFS_COMMAND_WORD: begin
				command_reg <= I_WDATA;
				cmd_pend_reg <= 1'b1;
			end
			`OFS_TRAP_ENABLE: trap_en_reg <= I_WDATA[15:0];
			`OFS_FAST_READ_DATA: fast_data_reg <= I_WDATA[7:0];
			default: ;
			endcase
		end
		if (st_clr) begin
			pin_flag_reg <= 1'b0;
			trap_stat_reg[`TS_TRAP] <= 1'b0;
		end
		if (pin_event)
			pin_flag_reg <= 1'b1;
		claim_reg <= 1'b0;
		if (I_IO_VALID && !I_IO_WRITE) begin
			if (trap_en_reg[`TEN_FAST_READ] &&
				fast_read_port(I_IO_ADDR, fm_on, sb_on, sb_sel)) begin
				claim_reg <= 1'b1;
				io_rdata_reg <= fast_data_reg;
			end else if (io_hit) begin
				trap_stat_reg[`TS_TRAP] <= 1'b1;
				trap_stat_reg[`TS_WRITE] <= 1'b0;
				trap_stat_reg[9:0] <= I_IO_ADDR;
			end
		end
		if (I_IO_VALID && I_IO_WRITE) begin
			if (trap_en_reg[`TEN_FAST_WRITE] && !trap_stat_reg[`TS_FW_PEND] &&
				fast_write_port(I_IO_ADDR, fm_on, sb_on, sb_sel)) begin
				trap_stat_reg[`TS_FW_PEND] <= 1'b1;
				trap_stat_reg[`TS_A1] <= I_IO_ADDR[1];
				trap_stat_reg[23:16] <= I_IO_WDATA;
			end else if (io_hit) begin
				trap_stat_reg[`TS_FW_PEND] <= 1'b0;
				trap_stat_reg[`TS_TRAP] <= 1'b1;
				trap_stat_reg[`TS_WRITE] <= 1'b1;
				trap_stat_reg[9:0] <= I_IO_ADDR;
				trap_stat_reg[31:24] <= I_IO_WDATA;
			end
		end
		irq_prev_reg <= irq_vec;
		if (top_clr)
			top_reg <= 1'b0;
		if (|(irq_vec & ~irq_prev_reg))
			top_reg <= 1'b1;
		rdata_reg <= `RST_WORD;
		if (I_RD) begin
			if (bm_hit)
				rdata_reg <= I_ADDR[2] ? ptr_reg[bm_idx] :
					{16'h0, 3'h0, state_reg[bm_idx], 4'h0,
					dir_reg[bm_idx], 2'h0,
					~state_reg[bm_idx][0]};
			else begin
				case (I_ADDR)
				`OFS_PIN_STATUS:
					rdata_reg <= {pin_flag_reg, 15'h0, I_CODEC_PIN_IN};
				`OFS_PIN_CONTROL: rdata_reg <= pin_ctrl_reg;
				`OFS_STATUS_WORD: rdata_reg <= status_word_reg;
				`OFS_COMMAND_WORD: rdata_reg <= command_reg;
				`OFS_IRQ_MIRROR, `OFS_IRQ_CLEAR:
					rdata_reg <= {16'h0, irq_vec};
				`OFS_TRAP_STATUS: rdata_reg <= trap_stat_reg;
				`OFS_TRAP_ENABLE: rdata_reg <= {16'h0, trap_en_reg};
				`OFS_FAST_READ_DATA: rdata_reg <= {24'h0, fast_data_reg};
				`OFS_TOP_MIRROR, `OFS_TOP_CLEAR:
					rdata_reg <= {31'h0, top_reg};
				default: rdata_reg <= `RST_WORD;
				endcase
			end
		end
	end
end

assign O_RDATA = rdata_reg;
assign O_MEM_REQ = mem_req_reg;
assign O_MEM_WE = mem_we_reg;
assign O_MEM_ADDR = mem_addr_reg;
assign O_MEM_WDATA = mem_wdata_reg;
assign O_PLAY_DATA = play_data_reg;
assign O_PLAY_VALID = play_valid_reg;
assign O_LINK_SYNC = sync_reg;
assign O_LINK_SERIAL_OUT = sdout_reg;
assign O_SPEAKER_TONE_OUT = tone_reg;
assign O_IO_CLAIM = claim_reg;
assign O_IO_RDATA = io_rdata_reg;
assign O_SYSTEM_MGMT_INTERRUPT = top_reg;

endmodule // audio_dma_core

`default_nettype wire

// >>> tb/audio_dma_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Port checker
// ----------------
module audio_dma_checker (
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	input wire logic [8:0] I_ADDR,
	input wire logic I_RD,
	input wire logic [31:0] O_RDATA,
	input wire logic O_MEM_REQ,
	input wire logic O_MEM_WE,
	input wire logic [31:0] O_MEM_ADDR,
	input wire logic [31:0] O_MEM_WDATA,
	input wire logic I_MEM_ACK,
	input wire logic [5:0] O_PLAY_VALID,
	input wire logic O_LINK_SYNC,
	input wire logic I_SPEAKER_TONE,
	input wire logic I_PIN_FUNCTION_SELECT,
	input wire logic O_SPEAKER_TONE_OUT,
	input wire logic I_IO_VALID,
	input wire logic I_IO_WRITE,
	input wire logic [9:0] I_IO_ADDR,
	input wire logic O_IO_CLAIM,
	input wire logic O_SYSTEM_MGMT_INTERRUPT
);
	wire fast_port = (I_IO_ADDR[9:2] == 8'he2) || (I_IO_ADDR[9:8] == 2'h2
		&& (I_IO_ADDR[3:0] < 4'h4 || I_IO_ADDR[3:1] == 3'h4));
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_NRST);
	sequence s_sync_hold;
		O_LINK_SYNC [*8];
	endsequence
	sequence s_top_clear;
		I_RD && I_ADDR == 9'h102;
	endsequence
	sequence s_waiting;
		O_MEM_REQ && !I_MEM_ACK;
	endsequence
	AST_TONE: assert property ($past(I_NRST, 3) |->
		O_SPEAKER_TONE_OUT == $past(I_PIN_FUNCTION_SELECT && I_SPEAKER_TONE))
		else $error("tone output wrong");
	AST_RD_IDLE: assert property (!I_RD |=> O_RDATA == 32'h0)
		else $error("read data without read");
	AST_REQ_HOLD: assert property (s_waiting |=> O_MEM_REQ
		&& $stable(O_MEM_ADDR)) else $error("request dropped");
	AST_REQ_QUAL: assert property (s_waiting |=> $stable(O_MEM_WE)
		&& $stable(O_MEM_WDATA)) else $error("request changed");
	AST_CLAIM: assert property (O_IO_CLAIM |->
		$past(I_IO_VALID && !I_IO_WRITE && fast_port))
		else $error("claim without fast read");
	AST_PLAY_EVEN: assert property ((O_PLAY_VALID & 6'h2a) == 6'h0)
		else $error("capture master played");
	AST_SYNC: assert property ($rose(O_LINK_SYNC) |=> s_sync_hold)
		else $error("frame sync too short");
	AST_SMI_CLR: assert property ($fell(O_SYSTEM_MGMT_INTERRUPT) |->
		$past(I_RD && I_ADDR == 9'h102))
		else $error("interrupt fell without clear");
	AST_SMI_HOLD: assert property (O_SYSTEM_MGMT_INTERRUPT &&
		!s_top_clear |=> O_SYSTEM_MGMT_INTERRUPT)
		else $error("interrupt dropped without clear");
endmodule // audio_dma_checker
bind audio_dma_core audio_dma_checker u_chk (.I_SYS_CLK(I_SYS_CLK),
	.I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA),
	.O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE), .O_MEM_ADDR(O_MEM_ADDR),
	.O_MEM_WDATA(O_MEM_WDATA), .I_MEM_ACK(I_MEM_ACK),
	.O_PLAY_VALID(O_PLAY_VALID), .O_LINK_SYNC(O_LINK_SYNC),
	.I_SPEAKER_TONE(I_SPEAKER_TONE),
	.I_PIN_FUNCTION_SELECT(I_PIN_FUNCTION_SELECT),
	.O_SPEAKER_TONE_OUT(O_SPEAKER_TONE_OUT), .I_IO_VALID(I_IO_VALID),
	.I_IO_WRITE(I_IO_WRITE), .I_IO_ADDR(I_IO_ADDR), .O_IO_CLAIM(O_IO_CLAIM),
	.O_SYSTEM_MGMT_INTERRUPT(O_SYSTEM_MGMT_INTERRUPT));
`default_nettype wire

// >>> tb/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Memory and codec
// ----------------
module far_side_model (
	input wire logic i_clk,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_slow,
	output logic o_ack,
	output logic [31:0] o_rdata,
	output logic o_link_clk,
	output logic o_serial
);
	logic [31:0] mem [bit [31:0]];
	logic [31:0] log_q [$];
	logic [1:0] wait_cnt;
	initial begin
		o_ack = 1'b0;
		o_rdata = 32'h0;
		o_serial = 1'b0;
		o_link_clk = 1'b0;
		wait_cnt = 2'h0;
		#37;
		forever #200 o_link_clk = ~o_link_clk;
	end
	always @(posedge o_link_clk) begin
		o_serial <= ~o_serial;
	end
	// Read data only valid with ack
	always @(posedge i_clk) begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_req && !o_ack) begin
			if (wait_cnt != 2'h0) begin
				wait_cnt <= wait_cnt - 2'h1;
			end else begin
				o_ack <= 1'b1;
				log_q.push_back(i_addr);
				if (i_we) begin
					mem[i_addr] = i_wdata;
				end
				o_rdata <= mem.exists(i_addr) ? mem[i_addr] :
					i_addr ^ 32'h5a5a_0000;
				wait_cnt <= i_slow ? i_addr[3:2] + 2'h1 : 2'h0;
			end
		end
	end
endmodule // far_side_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, n_rst, wr_s, rd_s, io_v, io_w, sel, tone, slow;
	logic req, we, ack, lclk, sin, sync, sout, tout, claim, system_mgmt_interrupt;
	logic [8:0] addr;
	logic [31:0] wdata, rdata, v, cap, maddr, mwd, mrd, pdata, seed;
	logic [31:0] exp_q [$];
	logic [31:0] play_q [$];
	logic [5:0] xfer, pv;
	logic [9:0] io_a;
	logic [7:0] io_d, iord;
	logic [15:0] pins;
	int n_errors, cmp_count, cyc;
	audio_dma_core u_dut (.I_SYS_CLK(clk), .I_NRST(n_rst), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
		.O_MEM_REQ(req), .O_MEM_WE(we), .O_MEM_ADDR(maddr),
		.O_MEM_WDATA(mwd), .I_MEM_ACK(ack), .I_MEM_RDATA(mrd),
		.I_XFER_REQ(xfer), .O_PLAY_DATA(pdata), .O_PLAY_VALID(pv),
		.I_CAP_DATA(cap), .I_LINK_CLK(lclk), .I_FIRST_CODEC_SERIAL_IN(sin),
		.O_LINK_SYNC(sync), .O_LINK_SERIAL_OUT(sout), .I_CODEC_PIN_IN(pins),
		.I_SPEAKER_TONE(tone), .I_PIN_FUNCTION_SELECT(sel),
		.O_SPEAKER_TONE_OUT(tout), .I_IO_VALID(io_v), .I_IO_WRITE(io_w),
		.I_IO_ADDR(io_a), .I_IO_WDATA(io_d), .O_IO_CLAIM(claim),
		.O_IO_RDATA(iord), .O_SYSTEM_MGMT_INTERRUPT(system_mgmt_interrupt));
	far_side_model u_far (.i_clk(clk), .i_req(req), .i_we(we),
		.i_addr(maddr), .i_wdata(mwd), .i_slow(slow), .o_ack(ack),
		.o_rdata(mrd), .o_link_clk(lclk), .o_serial(sin));
	// ----------------
	// Helpers
	// ----------------
	task automatic end_of_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic ok, input logic [31:0] where);
		cmp_count++;
		if (!ok) begin
			n_errors++;
			$display("FAIL %0t mismatch near %h", $time, where);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [31:0] m, e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk((rdata & m) === e, {23'h0, a});
	endtask
	task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic e);
		@(posedge clk);
		io_v <= 1'b1;
		io_w <= w;
		io_a <= a;
		io_d <= d;
		@(posedge clk);
		io_v <= 1'b0;
		@(negedge clk);
		chk(claim === e, {22'h0, a});
	endtask
	task automatic cmp_log;
		foreach (exp_q[k]) chk(u_far.log_q[k] === exp_q[k], exp_q[k]);
		chk(u_far.log_q.size() == exp_q.size(), 32'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Sampled away from the launching edge
	always @(negedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			end_of_test();
		end
		if (pv[0]) chk(pdata === play_q.pop_front(), 32'h1);
	end
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		seed = 32'h3699fad6;
		{n_rst, wr_s, rd_s, io_v, io_w, sel, tone, slow} = 8'h0;
		{addr, wdata, xfer, io_a, io_d} = 65'h0;
		cap = $random(seed);
		pins = 16'($random(seed));
		repeat (2) @(posedge clk);
		n_rst <= 1'b1;
		repeat (3) @(posedge clk);
		rd(9'h010, 32'hffff, 32'h0);
		rd(9'h1fc, 32'hffffffff, 32'h0);
		wr(9'h014, $random(seed));
		rd(9'h014, 32'hffffffff, 32'h0);
		v = $random(seed);
		wr(9'h00c, v);
		rd(9'h00c, 32'hff00ffff, v & 32'hff00ffff);
		wr(9'h004, v);
		rd(9'h004, 32'hffff, v & 32'hffff);
		repeat (20) begin
			@(posedge clk);
			{sel, tone} <= 2'($random(seed));
		end
		@(posedge clk);
		@(negedge clk);
		chk(tout === (sel & tone), 32'h0);
		wr(9'h018, 32'h12);
		for (int i = 0; i < 4; i++) io(1'b0, 10'h388 + 10'(i), 8'h0, 1'b1);
		io(1'b0, 10'h220, 8'h0, 1'b0);
		wr(9'h018, 32'h11);
		for (int j = 0; j < 10; j++) io(1'b0, 10'h220 + 10'(j), 8'h0,
			j < 4 || j > 7);
		wr(9'h018, 32'h2);
		io(1'b0, 10'h389, 8'h0, 1'b0);
		rd(9'h012, 32'h2000, 32'h2000);
		wr(9'h018, 32'h803);
		v = $random(seed);
		io(1'b1, 10'h38a, v[7:0], 1'b0);
		rd(9'h014, 32'h00ff8000, {8'h0, v[7:0], 16'h8000});
		rd(9'h010, 32'h2000, 32'h0);
		io(1'b1, 10'h38b, 8'h5c, 1'b0);
		rd(9'h014, 32'h800, 32'h800);
		rd(9'h100, 32'h1, 32'h1);
		rd(9'h100, 32'h1, 32'h1);
		rd(9'h102, 32'h1, 32'h1);
		rd(9'h100, 32'h1, 32'h0);
		rd(9'h012, 32'h2000, 32'h2000);
		rd(9'h010, 32'hffff, 32'h0);
		u_far.mem[32'h1000] = 32'h2000;
		u_far.mem[32'h1004] = 32'h4000_0008;
		u_far.mem[32'h1008] = 32'h1013;
		u_far.mem[32'h100c] = 32'h2000_0000;
		exp_q = '{32'h1000, 32'h1004, 32'h2000, 32'h2004, 32'h1008,
			32'h100c, 32'h1000, 32'h1004, 32'h2000, 32'h2004};
		play_q = '{32'h5a5a_2000, 32'h5a5a_2004, 32'h5a5a_2000, 32'h5a5a_2004};
		u_far.log_q.delete();
		wr(9'h044, 32'h1000);
		wr(9'h040, 32'h1);
		repeat (4) begin
			repeat (16) @(posedge clk);
			xfer <= 6'h1;
			@(posedge clk);
			xfer <= 6'h0;
		end
		repeat (30) @(posedge clk);
		cmp_log();
		chk(system_mgmt_interrupt === 1'b1, 32'h2);
		rd(9'h010, 32'hfff, 32'h3);
		rd(9'h040, 32'h1f00, 32'h0800);
		slow <= 1'b1;
		rd(9'h012, 32'hfff, 32'h3);
		rd(9'h010, 32'hfff, 32'h0);
		exp_q = {exp_q, 32'h1008, 32'h100c, 32'h1000, 32'h1004};
		repeat (60) @(posedge clk);
		cmp_log();
		wr(9'h040, 32'h0);
		rd(9'h040, 32'h1f00, 32'h0400);
		end_of_test();
	end
endmodule // tb
`default_nettype wire
